// ==== core/usb_out_rsp.sv ====
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`include "usb_rsp_cfg.svh"

// How it works
// - bad address, endpoint or sequence invalidates header
// - CRC, abort, missing, length mismatch mean payload error
// - device answers each data packet at most once
// - ack names next expected sequence, reports free buffers
// - deferred and halted or ready: send ERDY
// - deferred not ready: silent, ERDY on resume
// - halted non-deferred endpoint gets STALL
// - cannot accept: discard and send NRDY
// - payload error: retry ack, expected sequence, count
// - good packet: ack next sequence and count
// - sequence counts modulo thirty-two
// - packet count drops by one at most
// - no further room: packet count zero
module usb_out_rsp
#(
   parameter int NUM_EP = 4,
   parameter int MAX_BURST = 16
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic rxPkt,
   input wire logic [6:0] rxDevAddr,
   input wire logic [3:0] rxEp,
   input wire logic rxDirIn,
   input wire usb_rsp_pkg::seq_t rxSeq,
   input wire logic rxDeferred,
   input wire logic [10:0] rxLen,
   input wire logic [10:0] rxPayLen,
   input wire logic rxCrcErr,
   input wire logic rxAbort,
   input wire logic rxMissing,
   input wire logic [NUM_EP-1:0][4:0] bufFree,
   output logic tpValid,
   output usb_rsp_pkg::rsp_kind_t tpKind,
   output logic [3:0] tpEp,
   output usb_rsp_pkg::seq_t tpSeq,
   output usb_rsp_pkg::nump_t tpNumP,
   output logic tpRetry
);
   import usb_rsp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // parameter checks

   // endpoint index must fit the four-bit endpoint field
   if (NUM_EP < 2 || NUM_EP > 16)
   begin : g_bad_ep
      $error("NUM_EP must lie in 2..16");
   end

   // the packet count field holds at most sixteen here
   if (MAX_BURST < 1 || MAX_BURST > 16)
   begin : g_bad_burst
      $error("MAX_BURST must lie in 1..16");
   end

   localparam int EPW = $clog2(NUM_EP);
   localparam logic [4:0] NEP5 = 5'(NUM_EP); // endpoint range limit
   localparam nump_t MAXB = nump_t'(MAX_BURST); // burst limit as a field

   ////////////////////////////////////////////////////////////////////////////
   // state

   // every flip-flop of the block except those of the reset synchroniser u_rst_sync
   typedef struct packed {
      logic [6:0] devAddr; // our address on the link
      logic [NUM_EP-1:0] epCfg; // OUT endpoints in the configuration
      logic [NUM_EP-1:0] halt; // halt feature per endpoint
      logic [NUM_EP-1:0] pend; // deferred packets owed an ERDY
      logic [NUM_EP-1:0][4:0] expSeq; // next expected sequence
      logic [NUM_EP-1:0][4:0] prevNumP; // count in the last ack sent
      logic tpValid;
      rsp_kind_t tpKind;
      logic [3:0] tpEp;
      seq_t tpSeq;
      nump_t tpNumP;
      logic tpRetry;
      logic [15:0] rspCount; // responses sent since reset
      logic wrPend; // write data phase due
      logic [7:0] wrAddr; // offset of that write
      logic rdy; // bus ready out
      logic [31:0] rdData; // read data for the data phase
      logic resp; // bus response
   } state_t;

   state_t s;
   state_t n;

   logic rstn; // synchronised reset

   ////////////////////////////////////////////////////////////////////////////
   // reset release

   rst_sync u_rst_sync
   (
      .clk(clk),
      .resetn(resetn),
      .rstnSync(rstn)
   );

   ////////////////////////////////////////////////////////////////////////////
   // header and payload checks

   logic [EPW-1:0] idx; // endpoint as an array index
   logic epOk; // endpoint in range and configured
   logic hdrBad; // header not valid for us
   logic payErr; // payload damaged
   logic canAccept; // buffer free on that endpoint
   logic dSend;
   rsp_kind_t dKind;
   logic dRetry;
   logic dAccept;
   logic dPend;

   assign idx = rxEp[EPW-1:0];

   // out-of-range endpoints count as unconfigured
   assign epOk = ({1'b0, rxEp} < NEP5) && s.epCfg[idx];

   // an IN direction cannot belong to an OUT endpoint
   assign hdrBad = (rxDevAddr != s.devAddr) || !epOk || rxDirIn
                   || (rxSeq != s.expSeq[idx]);

   // a missing payload is reported by the receiver itself
   assign payErr = rxCrcErr || rxAbort || rxMissing
                   || (rxLen != rxPayLen);

   assign canAccept = (bufFree[idx] != 5'h00);

   // one outcome per packet, in fixed priority
   rsp_decide u_rsp_decide
   (
      .hdrBad(hdrBad),
      .deferred(rxDeferred),
      .halted(s.halt[idx]),
      .canAccept(canAccept),
      .payErr(payErr),
      .send(dSend),
      .kind(dKind),
      .retry(dRetry),
      .accept(dAccept),
      .pend(dPend)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      logic [NUM_EP-1:0] resumeOk;
      logic [3:0] resEp;
      logic resHit;
      logic [31:0] last;
      nump_t cand;
      resumeOk = '0;
      resEp = 4'h0;
      resHit = 1'b0;
      last = 32'h0000_0000;
      cand = 5'h00;
      n = s;

      // response strobe lasts one cycle
      n.tpValid = 1'b0;
      n.rdy = 1'b1;
      n.resp = `RSP_HRESP_OKAY;

      // write data phase: hwdata is valid now
      if (s.wrPend)
      begin
         unique case (s.wrAddr)
            `RSP_REG_CTRL: n.devAddr = hwdata[6:0];
            `RSP_REG_EPCFG: n.epCfg = hwdata[NUM_EP-1:0];
            `RSP_REG_HALT: n.halt = hwdata[NUM_EP-1:0];
            `RSP_REG_SEQCLR:
            begin
               // endpoint re-initialised: restart at sequence zero
               for (int e = 0; e < NUM_EP; e++)
               begin
                  if (hwdata[e])
                  begin
                     n.expSeq[e] = 5'h00;
                     n.prevNumP[e] = 5'h00;
                  end
               end
            end
            default: ; // read-only or unmapped: ignored
         endcase
      end
      n.wrPend = 1'b0;

      // snapshot of the last response for software
      last[`RSP_LAST_KIND_LSB +: 2] = s.tpKind;
      last[`RSP_LAST_SEQ_LSB +: 5] = s.tpSeq;
      last[`RSP_LAST_NUMP_LSB +: 5] = s.tpNumP;
      last[`RSP_LAST_RETRY_BIT] = s.tpRetry;
      last[`RSP_LAST_EP_LSB +: 4] = s.tpEp;

      // address phase: read data is fetched now, so no wait states;
      // a read straight after a write to the same word sees the old value
      if (hsel && hready && htrans[1])
      begin
         n.wrPend = hwrite && (hsize == `RSP_HSIZE_WORD);
         n.wrAddr = haddr[7:0];
         n.rdData = 32'h0000_0000;
         if (!hwrite)
         begin
            unique case (haddr[7:0])
               `RSP_REG_CTRL: n.rdData[6:0] = s.devAddr;
               `RSP_REG_EPCFG: n.rdData[NUM_EP-1:0] = s.epCfg;
               `RSP_REG_HALT: n.rdData[NUM_EP-1:0] = s.halt;
               `RSP_REG_PEND: n.rdData[NUM_EP-1:0] = s.pend;
               `RSP_REG_COUNT: n.rdData[15:0] = s.rspCount;
               `RSP_REG_LAST: n.rdData = last;
               default: ; // unmapped and write-only words read zero
            endcase
         end
      end

      // deferred endpoints that may now be resumed; a halted one counts
      for (int e = NUM_EP - 1; e >= 0; e--)
      begin
         resumeOk[e] = s.pend[e] && (bufFree[e] != 5'h00 || s.halt[e]);
         if (resumeOk[e])
         begin
            resEp = 4'(e);
            resHit = 1'b1;
         end
      end

      if (rxPkt)
      begin
         // a received packet always takes the response slot
         if (dSend)
         begin
            n.tpValid = 1'b1;
            n.tpKind = dKind;
            n.tpEp = rxEp;
            n.tpRetry = dRetry;
            n.tpSeq = s.expSeq[idx];
            n.tpNumP = 5'h00;
            n.rspCount = s.rspCount + 16'h0001;
            if (dKind == RSP_ACK)
            begin
               // this packet takes one buffer only if kept
               cand = dAccept ? bufFree[idx] - 5'h01 : bufFree[idx];
               n.tpNumP = nump_limit(cand, s.prevNumP[idx], MAXB);
               n.prevNumP[idx] = n.tpNumP;
            end
            else
            begin
               // flow control or halt ends the burst
               n.prevNumP[idx] = 5'h00;
            end
            if (dAccept)
            begin
               // next expected number, wrapping after 31
               n.expSeq[idx] = s.expSeq[idx] + 5'h01;
               n.tpSeq = s.expSeq[idx] + 5'h01;
            end
         end
         if (dPend)
            n.pend[idx] = 1'b1;
      end
      else if (resHit)
      begin
         // resume a deferred endpoint with an ERDY
         n.tpValid = 1'b1;
         n.tpKind = RSP_ERDY;
         n.tpEp = resEp;
         n.tpRetry = 1'b0;
         n.tpSeq = s.expSeq[resEp[EPW-1:0]];
         n.tpNumP = 5'h00;
         n.pend[resEp[EPW-1:0]] = 1'b0;
         n.rspCount = s.rspCount + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   // constants only under reset; bus ready stands high from reset
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s <= '0;
         s.devAddr <= `RSP_DEVADDR_RST;
         s.epCfg <= NUM_EP'(`RSP_MASK_RST);
         s.halt <= NUM_EP'(`RSP_MASK_RST);
         s.rspCount <= `RSP_COUNT_RST;
         s.rdy <= 1'b1;
         s.resp <= `RSP_HRESP_OKAY;
      end
      else
      begin
         s <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, each straight from a flip-flop

   assign hreadyout = s.rdy;
   assign hrdata = s.rdData;
   assign hresp = s.resp;
   assign tpValid = s.tpValid;
   assign tpKind = s.tpKind;
   assign tpEp = s.tpEp;
   assign tpSeq = s.tpSeq;
   assign tpNumP = s.tpNumP;
   assign tpRetry = s.tpRetry;

endmodule // usb_out_rsp

// ==== core/usb_rsp_cfg.svh ====
`ifndef USB_RSP_CFG_SVH
`define USB_RSP_CFG_SVH

// register byte offsets (low address byte only)
`define RSP_REG_CTRL 8'h00
`define RSP_REG_EPCFG 8'h04
`define RSP_REG_HALT 8'h08
`define RSP_REG_SEQCLR 8'h0C
`define RSP_REG_PEND 8'h10
`define RSP_REG_COUNT 8'h14
`define RSP_REG_LAST 8'h18

// reset values
`define RSP_DEVADDR_RST 7'h00
`define RSP_MASK_RST 16'h0000
`define RSP_COUNT_RST 16'h0000

// field positions of the last-response register
`define RSP_LAST_KIND_LSB 0
`define RSP_LAST_SEQ_LSB 2
`define RSP_LAST_NUMP_LSB 7
`define RSP_LAST_RETRY_BIT 12
`define RSP_LAST_EP_LSB 13

// bus encodings
`define RSP_HSIZE_WORD 3'b010
`define RSP_HRESP_OKAY 1'b0

`endif

// ==== core/usb_rsp_pkg.sv ====
package usb_rsp_pkg;

   // transaction packet sent back for a received data packet
   typedef enum logic [1:0] {RSP_ACK, RSP_NRDY, RSP_ERDY, RSP_STALL} rsp_kind_t;

   // sequence number and packet count fields
   typedef logic [4:0] seq_t;
   typedef logic [4:0] nump_t;

   // clamp a packet count to the burst limit and keep any drop to one step;
   // a larger drop is reported as zero (no further room), the only legal jump
   function automatic nump_t nump_limit(input nump_t cand, input nump_t prev,
                                        input nump_t maxb);
      nump_t c;
      c = (cand > maxb) ? maxb : cand;
      if (prev != 5'h00 && c < prev - 5'h01)
         c = 5'h00;
      return c;
   endfunction

endpackage

// ==== core/rst_sync.sv ====
// releases an asynchronous active-low reset in step with the clock
module rst_sync
(
   input wire logic clk,
   input wire logic resetn,
   output logic rstnSync
);

   // two-stage release chain; only stage two looks at stage one
   typedef struct packed {
      logic stage1;
      logic stage2;
   } sync_t;

   sync_t s;
   sync_t n;

   // next value: shift a one through the chain
   always_comb
   begin
      n.stage1 = 1'b1;
      n.stage2 = s.stage1;
   end

   // assertion is immediate, release takes two edges
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         s <= '0;
      else
         s <= n;
   end

   assign rstnSync = s.stage2;

endmodule // rst_sync

// ==== core/rsp_decide.sv ====
// priority decision for one received OUT data packet
module rsp_decide
import usb_rsp_pkg::*;
(
   input wire logic hdrBad,
   input wire logic deferred,
   input wire logic halted,
   input wire logic canAccept,
   input wire logic payErr,
   output logic send,
   output usb_rsp_pkg::rsp_kind_t kind,
   output logic retry,
   output logic accept,
   output logic pend
);

   // order: header, deferred, halt, buffer, payload
   always_comb
   begin
      send = 1'b0;
      kind = RSP_ACK;
      retry = 1'b0;
      accept = 1'b0;
      pend = 1'b0;
      if (hdrBad)
      begin
         // silent discard
         send = 1'b0;
      end
      else if (deferred)
      begin
         // halted or ready: ERDY now; otherwise remember and stay quiet
         kind = RSP_ERDY;
         send = halted || canAccept;
         pend = !halted && !canAccept;
      end
      else if (halted)
      begin
         send = 1'b1;
         kind = RSP_STALL;
      end
      else if (!canAccept)
      begin
         send = 1'b1;
         kind = RSP_NRDY;
      end
      else if (payErr)
      begin
         send = 1'b1;
         retry = 1'b1;
      end
      else
      begin
         send = 1'b1;
         accept = 1'b1;
      end
   end

endmodule // rsp_decide

// ==== bench/usb_out_rsp_chk.sv ====
// watches the answer port against the packet that caused it
module usb_out_rsp_chk
#(
   parameter int NUM_EP = 4,
   parameter int MAX_BURST = 16
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic rxPkt,
   input wire logic [3:0] rxEp,
   input wire logic rxDirIn,
   input wire usb_rsp_pkg::seq_t rxSeq,
   input wire logic rxDeferred,
   input wire logic [10:0] rxLen,
   input wire logic [10:0] rxPayLen,
   input wire logic rxCrcErr,
   input wire logic rxAbort,
   input wire logic rxMissing,
   input wire logic [NUM_EP-1:0][4:0] bufFree,
   input wire logic tpValid,
   input wire usb_rsp_pkg::rsp_kind_t tpKind,
   input wire logic [3:0] tpEp,
   input wire usb_rsp_pkg::seq_t tpSeq,
   input wire usb_rsp_pkg::nump_t tpNumP,
   input wire logic tpRetry
);
   timeunit 1ns;
   timeprecision 100ps;
   import usb_rsp_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   logic payErr; // any payload fault of the current packet
   logic [4:0] freeNow; // free buffers of the addressed endpoint
   assign payErr = rxCrcErr | rxAbort | rxMissing | (rxLen != rxPayLen);
   assign freeNow = bufFree[rxEp];
   ////////////////////////////////////////////////////////////////////////////////
   // an answer that follows a packet belongs to that packet: resume is held off
   sequence ackAfter(e);
      rxPkt && payErr == e ##1 tpValid && tpKind == RSP_ACK;
   endsequence
   sequence kindAfter(k);
      rxPkt ##1 tpValid && tpKind == k;
   endsequence
   bad_dir_a: assert property (rxPkt && rxDirIn |=> !tpValid)
      else $error("answer to an IN header");
   bad_ep_a: assert property (rxPkt && rxEp >= NUM_EP |=> !tpValid)
      else $error("answer to an unknown endpoint");
   good_ack_a: assert property (ackAfter(1'b0) |-> !tpRetry && tpSeq == $past(rxSeq) + 5'h01)
      else $error("good packet acknowledged wrongly");
   retry_ack_a: assert property (ackAfter(1'b1) |-> tpRetry && tpSeq == $past(rxSeq))
      else $error("corrupt packet not retried");
   ack_count_a: assert property (kindAfter(RSP_ACK) |-> $past(freeNow) != 5'h00
      && tpNumP <= $past(freeNow) && tpNumP <= MAX_BURST) else $error("ack count out of range");
   nrdy_cause_a: assert property (kindAfter(RSP_NRDY) |-> $past(freeNow) == 5'h00
      && !$past(rxDeferred)) else $error("not-ready without cause");
   stall_cause_a: assert property (kindAfter(RSP_STALL) |-> !$past(rxDeferred))
      else $error("stall on a deferred header");
   resume_erdy_a: assert property (tpValid && !$past(rxPkt) |-> tpKind == RSP_ERDY
      && tpNumP == 5'h00) else $error("unprompted answer is not a resume");
   answer_ep_a: assert property (rxPkt ##1 tpValid |-> tpEp == $past(rxEp))
      else $error("answer names another endpoint");
   bus_okay_a: assert property (hresp == 1'b0 && hreadyout)
      else $error("bus response not okay");
endmodule // usb_out_rsp_chk

bind usb_out_rsp usb_out_rsp_chk #(.NUM_EP(NUM_EP), .MAX_BURST(MAX_BURST)) chk (.clk(clk),
   .resetn(resetn), .hreadyout(hreadyout), .hresp(hresp), .rxPkt(rxPkt), .rxEp(rxEp),
   .rxDirIn(rxDirIn), .rxSeq(rxSeq), .rxDeferred(rxDeferred), .rxLen(rxLen),
   .rxPayLen(rxPayLen), .rxCrcErr(rxCrcErr), .rxAbort(rxAbort), .rxMissing(rxMissing),
   .bufFree(bufFree), .tpValid(tpValid), .tpKind(tpKind), .tpEp(tpEp), .tpSeq(tpSeq),
   .tpNumP(tpNumP), .tpRetry(tpRetry));

// ==== bench/host_out_model.sv ====
// host side: sends OUT data packets and follows the device's acks
// it never answers device data, so it sends no transaction packet back
module host_out_model
(
   input wire logic clk,
   input wire logic tpValid,
   input wire usb_rsp_pkg::rsp_kind_t tpKind,
   input wire logic [3:0] tpEp,
   input wire usb_rsp_pkg::seq_t tpSeq,
   output logic rxPkt,
   output logic [6:0] rxDevAddr,
   output logic [3:0] rxEp,
   output logic rxDirIn,
   output usb_rsp_pkg::seq_t rxSeq,
   output logic rxDeferred,
   output logic [10:0] rxLen,
   output logic [10:0] rxPayLen,
   output logic rxCrcErr,
   output logic rxAbort,
   output logic rxMissing
);
   timeunit 1ns;
   timeprecision 100ps;
   import usb_rsp_pkg::*;
   logic [42:0] q = 43'h0; // fields of the packet in flight
   logic [42:0] junk = 43'h0; // toggles so stale fields never look valid
   seq_t nextSeq [16] = '{default: 5'h00}; // sequence the host sends next
   initial rxPkt = 1'b0;
   // outside a packet the fields carry a pattern that flips every cycle
   assign {rxDevAddr, rxEp, rxDirIn, rxSeq, rxDeferred, rxLen, rxPayLen, rxCrcErr, rxAbort,
      rxMissing} = rxPkt ? q : junk;
   ////////////////////////////////////////////////////////////////////////////////
   // every ack names the sequence to send next, retry included
   always @(posedge clk)
   begin
      junk <= ~junk;
      if (tpValid && tpKind == RSP_ACK)
         nextSeq[tpEp] <= tpSeq;
   end
   // one packet, one cycle of rxPkt; bad shifts the sequence off by three
   task automatic send(input logic [6:0] a, input logic [3:0] ep, input logic din, dfr, bad,
                       input logic [3:0] err);
      seq_t sq;
      @(posedge clk);
      // an ack that ends at this edge has not reached nextSeq yet
      sq = (tpValid && tpKind == RSP_ACK && tpEp == ep) ? tpSeq : nextSeq[ep];
      q <= {a, ep, din, sq + (bad ? 5'h03 : 5'h00), dfr, 11'h200,
         err[3] ? 11'h1FF : 11'h200, err[2:0]};
      rxPkt <= 1'b1;
      @(posedge clk);
      rxPkt <= 1'b0;
   endtask
endmodule // host_out_model

// ==== bench/test_data_packet_ack_response.sv ====
`include "usb_rsp_cfg.svh"

module test_data_packet_ack_response;
   timeunit 1ns;
   timeprecision 100ps;
   import usb_rsp_pkg::*;
   localparam logic [6:0] DEVA = 7'h2A; // device address given by software
   localparam logic [4:0] MAXB = 5'h0C; // short burst so the clamp is reached
   logic clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rng = 32'h0000002F;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic hreadyout, hresp, rxPkt, rxDirIn, rxDeferred, rxCrcErr, rxAbort, rxMissing;
   logic [6:0] rxDevAddr;
   logic [3:0] rxEp, tpEp, haltM = 4'h0;
   logic [10:0] rxLen, rxPayLen;
   logic [3:0][4:0] bufFree = 20'h0;
   logic tpValid, tpRetry;
   rsp_kind_t tpKind;
   seq_t rxSeq, tpSeq, expSeq [4] = '{default: 5'h00};
   nump_t tpNumP, prevNp [4] = '{default: 5'h00};
   int numErrors = 0, checked = 0, sent = 0;
   always #2.5 clk = ~clk;
   usb_out_rsp #(.NUM_EP(4), .MAX_BURST(12)) dut (.clk(clk), .resetn(resetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .rxPkt(rxPkt), .rxDevAddr(rxDevAddr), .rxEp(rxEp), .rxDirIn(rxDirIn), .rxSeq(rxSeq),
      .rxDeferred(rxDeferred), .rxLen(rxLen), .rxPayLen(rxPayLen), .rxCrcErr(rxCrcErr),
      .rxAbort(rxAbort), .rxMissing(rxMissing), .bufFree(bufFree), .tpValid(tpValid),
      .tpKind(tpKind), .tpEp(tpEp), .tpSeq(tpSeq), .tpNumP(tpNumP), .tpRetry(tpRetry));
   host_out_model host (.clk(clk), .tpValid(tpValid), .tpKind(tpKind), .tpEp(tpEp),
      .tpSeq(tpSeq), .rxPkt(rxPkt), .rxDevAddr(rxDevAddr), .rxEp(rxEp), .rxDirIn(rxDirIn),
      .rxSeq(rxSeq), .rxDeferred(rxDeferred), .rxLen(rxLen), .rxPayLen(rxPayLen),
      .rxCrcErr(rxCrcErr), .rxAbort(rxAbort), .rxMissing(rxMissing));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   // clamp to the burst, and a drop of more than one becomes zero
   function automatic nump_t limitNp(input nump_t c, input nump_t p);
      if (c > MAXB)
         c = MAXB;
      return (p != 5'h00 && c + 5'h01 < p) ? 5'h00 : c;
   endfunction
   task automatic finalReport();
      $display("checks %0d, mismatches %0d", checked, numErrors);
      if (numErrors == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         numErrors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // bounded wait for hready sampled high at a rising edge
   task automatic waitRdy();
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1)
      begin
         numErrors++;
         finalReport();
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      hsize <= 3'b010;
      waitRdy();
      htrans <= 2'b00;
      hwdata <= d;
      waitRdy();
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      ahb(1'b0, a, 32'h0, r);
      check(r, e);
   endtask
   // wait for an answer that no packet prompts
   task automatic waitTp();
      for (int n = 0; n < 20 && tpValid !== 1'b1; n++)
         @(posedge clk) #1;
      if (tpValid !== 1'b1)
      begin
         numErrors++;
         finalReport();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // send one packet and compare the answer with the priority table
   task automatic pkt(input logic [6:0] a, input logic [3:0] ep, input logic din, dfr, bad,
                      input logic [3:0] err);
      logic hb, pe, v;
      rsp_kind_t k;
      logic [4:0] fr;
      seq_t s;
      nump_t np;
      host.send(a, ep, din, dfr, bad, err);
      #1;
      fr = bufFree[ep[1:0]];
      hb = a != DEVA || ep > 4'h2 || din || bad;
      pe = err != 4'h0;
      v = !hb && !(dfr && !haltM[ep[1:0]] && fr == 5'h00);
      k = dfr ? RSP_ERDY : haltM[ep[1:0]] ? RSP_STALL : fr == 5'h00 ? RSP_NRDY : RSP_ACK;
      check(tpValid, v);
      if (v)
         sent++;
      if (v)
      begin
         check(tpKind, k);
         check(tpEp, ep);
      end
      if (!hb && k != RSP_ACK)
         prevNp[ep[1:0]] = 5'h00;
      if (v && k == RSP_ACK)
      begin
         s = expSeq[ep[1:0]] + (pe ? 5'h00 : 5'h01);
         np = limitNp(pe ? fr : fr - 5'h01, prevNp[ep[1:0]]);
         check(tpSeq, s);
         check(tpNumP, np);
         check(tpRetry, pe);
         prevNp[ep[1:0]] = np;
         expSeq[ep[1:0]] = s;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [31:0] x;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 8; i++)
         rd(8'(i * 4), 32'h0);
      // a write to a read-only word must leave it untouched
      wr(`RSP_REG_PEND, 32'h0000000F);
      rd(`RSP_REG_PEND, 32'h0);
      rd(`RSP_REG_CTRL, 32'h0);
      wr(`RSP_REG_CTRL, {25'h0, DEVA});
      wr(`RSP_REG_EPCFG, 32'h7);
      rd(`RSP_REG_CTRL, {25'h0, DEVA});
      $display("test registers done");
      // deferred on a starved endpoint: silent, then a resume once room appears
      pkt(DEVA, 4'h2, 1'b0, 1'b1, 1'b0, 4'h0);
      rd(`RSP_REG_PEND, 32'h4);
      bufFree[2] <= 5'h03;
      waitTp();
      sent++;
      check(tpKind, RSP_ERDY);
      check(tpNumP, 5'h00);
      check(tpSeq, expSeq[2]);
      pkt(DEVA, 4'h2, 1'b0, 1'b1, 1'b0, 4'h0);
      wr(`RSP_REG_HALT, 32'h2);
      haltM = 4'h2;
      pkt(DEVA, 4'h1, 1'b0, 1'b1, 1'b0, 4'h0);
      pkt(DEVA, 4'h1, 1'b0, 1'b0, 1'b0, 4'h1);
      wr(`RSP_REG_HALT, 32'h0);
      haltM = 4'h0;
      pkt(DEVA, 4'h5, 1'b0, 1'b0, 1'b0, 4'h0);
      @(posedge clk);
      bufFree[0] <= 5'h06;
      for (int k = 0; k < 4; k++)
         pkt(DEVA, 4'h0, 1'b0, 1'b0, 1'b0, 4'h1 << k);
      // clearing the endpoint forgets the last count, so a low level is no drop
      wr(`RSP_REG_SEQCLR, 32'h1);
      prevNp[0] = 5'h00;
      bufFree[0] <= 5'h02;
      pkt(DEVA, 4'h0, 1'b0, 1'b0, 1'b0, 4'h1);
      $display("test corner cases done");
      // random mix: wrong address, direction, sequence, faults and buffer levels
      for (int i = 0; i < 400; i++)
      begin
         x = xs();
         @(posedge clk);
         bufFree[x[1:0]] <= x[6:2];
         pkt(x[10:8] == 3'b000 ? DEVA ^ 7'h01 : DEVA, {2'b00, x[1:0]}, x[13:11] == 3'b000,
            1'b0, x[16:14] == 3'b000, x[20:17] & {4{x[21] & x[22]}});
      end
      rd(`RSP_REG_COUNT, sent);
      $display("test random traffic done");
      finalReport();
   end
endmodule // test_data_packet_ack_response
